// >>> core/diag_link_if.sv
// Carrier between the register group and its strap and pool-reset helpers.
`timescale 1ns/1ps
interface diag_link_if;
    import diag_pkg::*;
    logic [5:0] pool_ctl;
    logic [N_POOLS-1:0] pool_pulse;
    logic [25:0] strap_raw;
    logic [31:0] strap_word;
    modport ctl (output pool_ctl, output strap_raw, input pool_pulse, input strap_word);
    modport pool (input pool_ctl, output pool_pulse);
    modport strap (input strap_raw, output strap_word);
endinterface

// >>> core/diag_pkg.sv
// Shared register map, field layout and timing constants of the diagnostic register group.
package diag_pkg;
    // Management address width and the printed register offsets.
    localparam int ADDR_W = 12;
    localparam logic [11:0] A_TSEL_LO = 12'hE00;
    localparam logic [11:0] A_TSEL_HI = 12'hE01;
    localparam logic [11:0] A_TOUT_LO = 12'hE02;
    localparam logic [11:0] A_TOUT_HI = 12'hE03;
    localparam logic [11:0] A_MASK = 12'hE10;
    localparam logic [11:0] A_STRAP = 12'hE80;
    localparam logic [11:0] A_WATCH = 12'hE90;
    localparam logic [11:0] A_PSTAT = 12'hEA0;
    localparam logic [11:0] A_CPUST = 12'hEA8;
    localparam logic [11:0] A_UPST = 12'hEAA;
    localparam logic [11:0] A_CLASS = 12'hEAC;
    localparam logic [11:0] A_IRQEN = 12'hEAD;
    localparam logic [11:0] A_QCTL = 12'hEB0;
    localparam logic [11:0] A_QENG = 12'hEBA;
    localparam logic [11:0] A_BIST = 12'hEBB;
    localparam logic [11:0] A_REPAIR = 12'hEBD;
    localparam logic [11:0] A_POOL = 12'hEC0;
    // Register counts.
    localparam int N_MASK = 5;
    localparam int N_STRAP = 4;
    localparam int N_PORTS = 10;
    localparam int N_FE = 8;
    localparam int N_POOLS = 15;
    localparam int N_WATCH = 5;
    // Writable and readable bit masks, and the common reset value.
    localparam logic [7:0] QCTL_MASK = 8'hE3;
    localparam logic [7:0] PSTAT_MASK = 8'hF7;
    localparam logic [15:0] WIDE_MASK = 16'h3FF7;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Field positions.
    localparam int POOL_ALL_BIT = 4;
    localparam int POOL_GO_BIT = 5;
    localparam logic [3:0] POOL_SEL_NONE = 4'hF;
    // Watchdog window: five seconds at the 50 MHz core clock.
    localparam longint WATCH_TIME_MS = 5000;
    localparam longint CLK_KHZ = 50000;
    localparam int WATCH_CYCLES = int'(WATCH_TIME_MS * CLK_KHZ);
    // Pool reset edge detector states.
    typedef enum logic [0:0] {POOL_WAIT_LOW = 1'b0, POOL_ARMED = 1'b1} pool_state_t;
endpackage

// >>> core/pool_reset_ctrl.sv
// Edge-triggered buffer pool reset: one pulse per zero-to-one change of the go bit, except with select 4'hF and bit 4 clear.
`timescale 1ns/1ps
module pool_reset_ctrl (
    input wire logic mclk,
    input wire logic sys_rst,
    diag_link_if.pool lk
);
    import diag_pkg::*;
    typedef struct packed {
        pool_state_t st;
        logic [N_POOLS-1:0] pulse;
    } pool_regs_t;
    pool_regs_t s_reg;
    pool_regs_t s_next;
    logic go;
    logic all;
    logic [3:0] sel;

    assign go = lk.pool_ctl[POOL_GO_BIT];
    assign all = lk.pool_ctl[POOL_ALL_BIT];
    assign sel = lk.pool_ctl[3:0];

    // A go bit left high does nothing more until software drops it again.
    always_comb begin
        s_next = s_reg;
        s_next.pulse = '0;
        case (s_reg.st)
            POOL_WAIT_LOW: begin
                if (!go) begin
                    s_next.st = POOL_ARMED;
                end
            end
            POOL_ARMED: begin
                if (go) begin
                    s_next.st = POOL_WAIT_LOW;
                    if (all) begin
                        s_next.pulse = '1;
                    end else if (sel != POOL_SEL_NONE) begin
                        s_next.pulse = N_POOLS'(1) << sel;
                    end
                end
            end
            default: s_next.st = POOL_WAIT_LOW;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_reg <= '{st: POOL_WAIT_LOW, pulse: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign lk.pool_pulse = s_reg.pulse;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    property p_pool_once;
        (s_reg.st == POOL_WAIT_LOW) |=> (s_reg.pulse == '0);
    endproperty
    a_pool_once: assert property (p_pool_once) else $error("Pool reset repeated.");
    property p_pool_all;
        (s_reg.st == POOL_ARMED) && go && all |=> s_reg.pulse == '1;
    endproperty
    a_pool_all: assert property (p_pool_all) else $error("All-pools reset missed.");
    property p_pool_sel;
        (s_reg.st == POOL_ARMED) && go && !all |=>
            s_reg.pulse == (($past(sel) == POOL_SEL_NONE) ? '0 : N_POOLS'(1) << $past(sel));
    endproperty
    a_pool_sel: assert property (p_pool_sel) else $error("Pool select decode wrong.");
    c_pool: cover property (s_reg.pulse != '0);
endmodule

// >>> core/strap_latch.sv
// Power-up strap capture with the documented bit reordering.
`timescale 1ns/1ps
module strap_latch (
    input wire logic mclk,
    input wire logic sys_rst,
    diag_link_if.strap lk
);
    import diag_pkg::*;
    typedef struct packed {
        logic done;
        logic [31:0] word;
    } strap_t;
    strap_t s_reg;
    strap_t s_next;

    // Sample once, on the first edge after reset release, then hold forever.
    always_comb begin
        s_next = s_reg;
        if (!s_reg.done) begin
            s_next.done = 1'b1;
            s_next.word = {6'h00, lk.strap_raw[25:16], 1'b0, lk.strap_raw[14:12],
                lk.strap_raw[10], lk.strap_raw[9], lk.strap_raw[11],
                ~lk.strap_raw[8:7], lk.strap_raw[6:0]};
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign lk.strap_word = s_reg.word;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    property p_strap_tx;
        $rose(s_reg.done) |-> s_reg.word[25:16] == $past(lk.strap_raw[25:16]);
    endproperty
    a_strap_tx: assert property (p_strap_tx) else $error("Transmit straps not captured.");
    property p_strap_order;
        $rose(s_reg.done) |-> s_reg.word[9] == $past(lk.strap_raw[11]) && !s_reg.word[15]
            && s_reg.word[8:7] == ~$past(lk.strap_raw[8:7]);
    endproperty
    a_strap_order: assert property (p_strap_order) else $error("Strap reorder wrong.");
    c_strap: cover property (s_reg.done ##1 s_reg.word != '0);
endmodule

// >>> core/switch_diag_status_control.sv
// Diagnostic and buffer-manager register group of the switch core.
`timescale 1ns/1ps
// Notes on behaviour
// - Test multiplexer output reads as two bytes, low byte first.
// - Five mask bytes; set bits block the automatic timeout reset.
// - Strap bits 15:0 from test pins with fixed inversion and reordering; bit 15 zero.
// - Strap bits 23:16 port transmit enables, 25:24 uplink straps, rest zero.
// - Per-port watch flags for five-second busy machines plus heartbeat seen and timeout.
// - Ports 0-7 status byte: buffer, congestion, WRED and multicast full flags.
// - CPU port sixteen-bit status with per-queue WRED and multicast full flags.
// - Uplink port sixteen-bit status, same layout as the CPU port.
// - Interrupt for each enabled buffer, WRED, multicast or heartbeat condition.
// - Class status byte; enable bit 7 interrupts on no class buffer.
// - Per-port control: bit 0 suspends departures, bit 1 resets the queue.
// - Per-port bits 5, 6, 7 force MAC control, XOFF and XON frames.
// - Queue engine control halts the two machines and stops grant and release.
// - Repair field zero uses detected swap map; nonzero overrides it.
// - Pool select picks port, uplink, shared, class, multicast or CPU pool.
// - Pool-reset bit 4 selects every pool.
// - Pool reset acts only on a zero-to-one change of bit 5.
// - Two registers select the test group for each test output byte.
module switch_diag_status_control #(
    parameter int unsigned WATCH_CYCLES = diag_pkg::WATCH_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [diag_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic [15:0] test_mux_out,
    output logic [7:0] test_group_sel_lo,
    output logic [7:0] test_group_sel_hi,
    input wire logic [15:0] strap_test_pins,
    input wire logic [diag_pkg::N_FE-1:0] port_tx_enable_straps,
    input wire logic uplink_tx_enable_strap,
    input wire logic uplink_tx_error_strap,
    input wire logic [diag_pkg::N_PORTS-1:0][diag_pkg::N_WATCH-1:0] port_fsm_busy,
    input wire logic [diag_pkg::N_PORTS-1:0] link_heartbeat_seen,
    input wire logic [diag_pkg::N_PORTS-1:0] link_heartbeat_timeout,
    input wire logic [diag_pkg::N_FE-1:0][7:0] port_buf_status,
    input wire logic [15:0] cpu_port_status,
    input wire logic [15:0] uplink_status,
    input wire logic [3:0] class_status,
    input wire logic [15:0] memory_selftest_result,
    input wire logic [3:0] hw_swap_map,
    output logic irq,
    output logic timeout_reset,
    output logic [diag_pkg::N_PORTS-1:0] port_suspend,
    output logic [diag_pkg::N_PORTS-1:0] port_queue_reset,
    output logic [diag_pkg::N_PORTS-1:0] force_mac_ctrl,
    output logic [diag_pkg::N_PORTS-1:0] force_xoff,
    output logic [diag_pkg::N_PORTS-1:0] force_xon,
    output logic queue_manager_halt,
    output logic multicast_queue_halt,
    output logic grant_stop,
    output logic release_stop,
    output logic [3:0] swap_map,
    output logic [diag_pkg::N_POOLS-1:0] pool_reset_pulse
);
    import diag_pkg::*;

    localparam int TW = $clog2(WATCH_CYCLES);

    // The watch window must be at least two cycles for the tick counter to exist.
    if (WATCH_CYCLES < 2) begin : g_bad_watch
        $error("WATCH_CYCLES must be at least 2.");
    end

    typedef struct packed {
        logic [7:0] sel_lo;
        logic [7:0] sel_hi;
        logic [N_MASK-1:0][7:0] mask;
        logic [N_PORTS-1:0][7:0] qctl;
        logic [3:0] qeng;
        logic [3:0] repair;
        logic [3:0] swap;
        logic [5:0] pool;
        logic [7:0] irq_en;
        logic [7:0] rdata;
        logic irq;
        logic tmo;
        logic [TW-1:0] tick;
        logic [N_PORTS-1:0][N_WATCH-1:0] idle_seen;
        logic [N_PORTS-1:0][N_WATCH-1:0] watch;
    } diag_regs_t;

    diag_regs_t s_reg;
    diag_regs_t s_next;
    diag_link_if lk ();
    logic [7:0] rd_val;
    logic [7:0] cond;
    logic tick_hit;

    // True when the address falls inside a block of n consecutive registers.
    function automatic logic in_block(input logic [11:0] a, input logic [11:0] base, input int n);
        logic [11:0] d;
        d = a - base;
        return (a >= base) && (d < 12'(n));
    endfunction

    // Folds a sixteen-bit CPU or uplink status into the six shared event classes.
    function automatic logic [5:0] fold_wide(input logic [15:0] v);
        return {|v[13:10], v[5] | v[7] | v[9], v[4] | v[6] | v[8], v[2], v[1], v[0]};
    endfunction

    // Folds a fast-port status byte into the same six event classes.
    function automatic logic [5:0] fold_byte(input logic [7:0] v);
        return {v[7] | v[6], v[5], v[4], v[2], v[1], v[0]};
    endfunction

    // Straps travel to the latch as one word; the latch owns the reordering.
    assign lk.strap_raw = {uplink_tx_error_strap, uplink_tx_enable_strap, port_tx_enable_straps, strap_test_pins};
    assign lk.pool_ctl = s_reg.pool;

    strap_latch u_strap (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .lk(lk.strap)
    );

    pool_reset_ctrl u_pool (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .lk(lk.pool)
    );

    // Event classes from the live status inputs; nothing here is sticky.
    always_comb begin
        logic [5:0] acc;
        acc = fold_wide(cpu_port_status) | fold_wide(uplink_status);
        for (int p = 0; p < N_FE; p++) begin
            acc = acc | fold_byte(port_buf_status[p]);
        end
        cond = {|class_status[3:1], |link_heartbeat_timeout, acc};
    end

    // Read multiplexer; status is sampled at the read, unmapped addresses return zero.
    always_comb begin
        logic [3:0] i;
        i = 4'h0;
        rd_val = RST_BYTE;
        if (cpu_addr == A_TSEL_LO) begin
            rd_val = s_reg.sel_lo;
        end else if (cpu_addr == A_TSEL_HI) begin
            rd_val = s_reg.sel_hi;
        end else if (cpu_addr == A_TOUT_LO) begin
            rd_val = test_mux_out[7:0];
        end else if (cpu_addr == A_TOUT_HI) begin
            rd_val = test_mux_out[15:8];
        end else if (in_block(cpu_addr, A_MASK, N_MASK)) begin
            i = 4'(cpu_addr - A_MASK);
            rd_val = s_reg.mask[i];
        end else if (in_block(cpu_addr, A_STRAP, N_STRAP)) begin
            i = 4'(cpu_addr - A_STRAP);
            rd_val = lk.strap_word[i[1:0]*8 +: 8];
        end else if (in_block(cpu_addr, A_WATCH, N_PORTS)) begin
            i = 4'(cpu_addr - A_WATCH);
            rd_val = {link_heartbeat_timeout[i], link_heartbeat_seen[i], 1'b0, s_reg.watch[i]};
        end else if (in_block(cpu_addr, A_PSTAT, N_FE)) begin
            i = 4'(cpu_addr - A_PSTAT);
            rd_val = port_buf_status[i[2:0]] & PSTAT_MASK;
        end else if (cpu_addr == A_CPUST) begin
            rd_val = cpu_port_status[7:0] & WIDE_MASK[7:0];
        end else if (cpu_addr == A_CPUST + 12'h001) begin
            rd_val = cpu_port_status[15:8] & WIDE_MASK[15:8];
        end else if (cpu_addr == A_UPST) begin
            rd_val = uplink_status[7:0] & WIDE_MASK[7:0];
        end else if (cpu_addr == A_UPST + 12'h001) begin
            rd_val = uplink_status[15:8] & WIDE_MASK[15:8];
        end else if (cpu_addr == A_CLASS) begin
            rd_val = {4'h0, class_status};
        end else if (cpu_addr == A_IRQEN) begin
            rd_val = s_reg.irq_en;
        end else if (in_block(cpu_addr, A_QCTL, N_PORTS)) begin
            i = 4'(cpu_addr - A_QCTL);
            rd_val = s_reg.qctl[i];
        end else if (cpu_addr == A_QENG) begin
            rd_val = {4'h0, s_reg.qeng};
        end else if (cpu_addr == A_BIST) begin
            rd_val = memory_selftest_result[7:0];
        end else if (cpu_addr == A_BIST + 12'h001) begin
            rd_val = memory_selftest_result[15:8];
        end else if (cpu_addr == A_REPAIR) begin
            rd_val = {4'h0, s_reg.repair};
        end else if (cpu_addr == A_POOL) begin
            rd_val = {2'b00, s_reg.pool};
        end
    end

    assign tick_hit = (s_reg.tick == TW'(WATCH_CYCLES - 1));

    // Register writes, watchdog windows, timeout reset and interrupt level.
    always_comb begin
        logic [3:0] i;
        logic [N_MASK*8-1:0] fe_watch;
        logic unmasked;
        i = 4'h0;
        s_next = s_reg;
        if (cpu_rd) begin
            s_next.rdata = rd_val;
        end
        if (cpu_wr) begin
            if (cpu_addr == A_TSEL_LO) begin
                s_next.sel_lo = cpu_wdata;
            end else if (cpu_addr == A_TSEL_HI) begin
                s_next.sel_hi = cpu_wdata;
            end else if (in_block(cpu_addr, A_MASK, N_MASK)) begin
                i = 4'(cpu_addr - A_MASK);
                s_next.mask[i] = cpu_wdata;
            end else if (cpu_addr == A_IRQEN) begin
                s_next.irq_en = cpu_wdata;
            end else if (in_block(cpu_addr, A_QCTL, N_PORTS)) begin
                i = 4'(cpu_addr - A_QCTL);
                s_next.qctl[i] = cpu_wdata & QCTL_MASK;
            end else if (cpu_addr == A_QENG) begin
                s_next.qeng = cpu_wdata[3:0];
            end else if (cpu_addr == A_REPAIR) begin
                s_next.repair = cpu_wdata[3:0];
            end else if (cpu_addr == A_POOL) begin
                s_next.pool = cpu_wdata[5:0];
            end
        end
        // A machine is flagged once it has been busy through a whole window;
        // the flag drops as soon as the machine goes idle.
        s_next.tick = tick_hit ? '0 : s_reg.tick + TW'(1);
        for (int p = 0; p < N_PORTS; p++) begin
            for (int k = 0; k < N_WATCH; k++) begin
                if (tick_hit) begin
                    s_next.watch[p][k] = !s_reg.idle_seen[p][k] && port_fsm_busy[p][k];
                    s_next.idle_seen[p][k] = !port_fsm_busy[p][k];
                end else begin
                    s_next.watch[p][k] = s_reg.watch[p][k] && port_fsm_busy[p][k];
                    s_next.idle_seen[p][k] = s_reg.idle_seen[p][k] || !port_fsm_busy[p][k];
                end
            end
        end
        // Fast ports map one mask bit per machine; CPU and uplink machines are not maskable.
        fe_watch = s_reg.watch[N_FE-1:0];
        unmasked = |(fe_watch & ~s_reg.mask) || |s_reg.watch[N_PORTS-1:N_FE];
        s_next.tmo = unmasked;
        s_next.irq = |(cond & s_reg.irq_en);
        s_next.swap = (s_reg.repair == 4'h0) ? hw_swap_map : s_reg.repair;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Control fields drive the queue and memory logic straight from the registers.
    always_comb begin
        for (int p = 0; p < N_PORTS; p++) begin
            port_suspend[p] = s_reg.qctl[p][0];
            port_queue_reset[p] = s_reg.qctl[p][1];
            force_mac_ctrl[p] = s_reg.qctl[p][5];
            force_xoff[p] = s_reg.qctl[p][6];
            force_xon[p] = s_reg.qctl[p][7];
        end
    end

    assign queue_manager_halt = s_reg.qeng[0];
    assign multicast_queue_halt = s_reg.qeng[1];
    assign grant_stop = s_reg.qeng[2];
    assign release_stop = s_reg.qeng[3];
    assign cpu_rdata = s_reg.rdata;
    assign test_group_sel_lo = s_reg.sel_lo;
    assign test_group_sel_hi = s_reg.sel_hi;
    assign irq = s_reg.irq;
    assign timeout_reset = s_reg.tmo;
    assign swap_map = s_reg.swap;
    assign pool_reset_pulse = lk.pool_pulse;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_test_out;
        cpu_rd && cpu_addr == A_TOUT_HI |=> cpu_rdata == $past(test_mux_out[15:8]);
    endproperty
    a_test_out: assert property (p_test_out) else $error("Test output high byte wrong.");
    property p_mask_blocks;
        s_reg.watch[0][0] && s_reg.mask[0][0] && s_reg.watch[0][N_WATCH-1:1] == '0
            && s_reg.watch[N_FE-1:1] == '0
            && s_reg.watch[N_PORTS-1:N_FE] == '0 |=> !timeout_reset;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("Masked watch caused reset.");
    property p_watch_busy;
        s_reg.watch[0][0] |-> $past(port_fsm_busy[0][0]);
    endproperty
    a_watch_busy: assert property (p_watch_busy) else $error("Watch flag on an idle machine.");
    property p_port_status;
        cpu_rd && cpu_addr == A_PSTAT |=> cpu_rdata == ($past(port_buf_status[0]) & PSTAT_MASK);
    endproperty
    a_port_status: assert property (p_port_status) else $error("Port status byte wrong.");
    property p_cpu_status;
        cpu_rd && cpu_addr == A_CPUST + 12'h001 |=> cpu_rdata == {2'b00, $past(cpu_port_status[13:8])};
    endproperty
    a_cpu_status: assert property (p_cpu_status) else $error("CPU status high byte wrong.");
    property p_up_status;
        cpu_rd && cpu_addr == A_UPST |=> cpu_rdata == ($past(uplink_status[7:0]) & 8'hF7);
    endproperty
    a_up_status: assert property (p_up_status) else $error("Uplink status low byte wrong.");
    property p_irq_gate;
        (s_reg.irq_en == 8'h00) [*2] |-> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Interrupt without enable.");
    property p_irq_raise;
        s_reg.irq_en[6] && |link_heartbeat_timeout |=> irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("Heartbeat interrupt missed.");
    property p_class_irq;
        s_reg.irq_en[7] && class_status[2] |=> irq;
    endproperty
    a_class_irq: assert property (p_class_irq) else $error("Class buffer interrupt missed.");
    property p_suspend;
        cpu_wr && cpu_addr == A_QCTL + 12'h003 |=> port_suspend[3] == $past(cpu_wdata[0])
            && force_xoff[3] == $past(cpu_wdata[6]);
    endproperty
    a_suspend: assert property (p_suspend) else $error("Port control write lost.");
    property p_qeng;
        cpu_wr && cpu_addr == A_QENG |=> {release_stop, grant_stop, multicast_queue_halt,
            queue_manager_halt} == $past(cpu_wdata[3:0]);
    endproperty
    a_qeng: assert property (p_qeng) else $error("Queue engine control wrong.");
    property p_repair;
        !sys_rst && s_reg.repair == 4'h0 ##1 s_reg.repair == 4'h0 |-> swap_map == $past(hw_swap_map);
    endproperty
    a_repair: assert property (p_repair) else $error("Detected swap map not used.");

    c_irq: cover property ($rose(irq));
    c_tmo: cover property ($rose(timeout_reset));
    c_pool: cover property (cpu_wr && cpu_addr == A_POOL ##2 pool_reset_pulse != '0);
endmodule

// >>> dv/host_model.sv
// Host CPU model that drives the management register port.
`timescale 1ns/1ps
module host_model (
    input wire logic mclk,
    output logic [diag_pkg::ADDR_W-1:0] cpu_addr,
    output logic cpu_wr,
    output logic cpu_rd,
    output logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata
);
    import diag_pkg::*;
    initial begin
        {cpu_addr, cpu_wr, cpu_rd, cpu_wdata} = '0;
    end
    // A strobe stands one cycle and drops on the edge that takes it, so no request is lost.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge mclk);
        cpu_wr <= 1'b0;
    endtask
    // Read data is registered, so it is picked up one edge after the strobe is taken.
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge mclk);
        cpu_rd <= 1'b0;
        @(posedge mclk);
        #1 d = cpu_rdata;
    endtask
    // Pool reset: stop grant and release, clear the go bit, then set it.
    task automatic pool(input logic [4:0] sel);
        wr(A_QENG, 8'h0C);
        wr(A_POOL, {3'h0, sel});
        wr(A_POOL, {3'h1, sel});
    endtask
endmodule

// >>> dv/switch_diag_status_control_test.sv
// Self-checking bench for the diagnostic register group.
`timescale 1ns/1ps
module switch_diag_status_control_test;
    import diag_pkg::*;
    logic mclk = 0, sys_rst = 1, wr, rd, irq, tr, gs, rs, qh, mh;
    logic [11:0] addr;
    logic [7:0] wd, rdat, d, sl, sh;
    logic [15:0] tm = 16'hBEEF, pins = 16'hFAA5, cps = 0, ups = 0, pp;
    logic [7:0] txen = 8'hA5;
    logic [9:0][4:0] busy = '0;
    logic [9:0] hbs = 0, hbt = 0, su, qr, fm, xf, xn;
    logic [7:0][7:0] pbs = '0;
    logic [3:0] cls = 0, hw = 4'h5, sm;
    logic [14:0] pul;
    int mismatches = 0, cmp_count = 0;
    always #10 mclk = ~mclk;
    host_model h (.mclk(mclk), .cpu_addr(addr), .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(wd), .cpu_rdata(rdat));
    switch_diag_status_control #(.WATCH_CYCLES(16)) dut (.mclk(mclk), .sys_rst(sys_rst), .cpu_addr(addr),
        .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(wd), .cpu_rdata(rdat), .test_mux_out(tm), .test_group_sel_lo(sl),
        .test_group_sel_hi(sh), .strap_test_pins(pins), .port_tx_enable_straps(txen), .uplink_tx_enable_strap(1'b1),
        .uplink_tx_error_strap(1'b0), .port_fsm_busy(busy), .link_heartbeat_seen(hbs), .link_heartbeat_timeout(hbt),
        .port_buf_status(pbs), .cpu_port_status(cps), .uplink_status(ups), .class_status(cls),
        .memory_selftest_result(16'h1234), .hw_swap_map(hw), .irq(irq), .timeout_reset(tr), .port_suspend(su),
        .port_queue_reset(qr), .force_mac_ctrl(fm), .force_xoff(xf), .force_xon(xn), .queue_manager_halt(qh),
        .multicast_queue_halt(mh), .grant_stop(gs), .release_stop(rs), .swap_map(sm), .pool_reset_pulse(pul));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Straps are reordered and partly inverted; unmapped places read zero.
    task automatic t_read();
        h.rd(12'hE80, d); chk("strap0", 8'h25, d);
        h.rd(12'hE81, d); chk("strap1", 8'h77, d);
        h.rd(12'hE82, d); chk("strap2", txen, d);
        h.rd(12'hE83, d); chk("strap3", 8'h01, d);
        h.rd(A_TOUT_HI, d); chk("tout_hi", tm[15:8], d);
        h.rd(A_TOUT_LO, d); chk("tout_lo", tm[7:0], d);
        h.wr(A_TSEL_LO, 8'hC3);
        h.wr(A_TSEL_HI, 8'h3C);
        h.rd(A_TSEL_HI, d); chk("sel_rd", 8'h3C, d);
        chk("sel_out", 16'h3CC3, {sh, sl});
        h.rd(12'hE20, d); chk("unmapped", 8'h00, d);
        h.wr(12'hE12, 8'h5A); h.rd(12'hE12, d); chk("mask2", 8'h5A, d);
    endtask
    // The interrupt follows enable and condition live; it is not sticky.
    task automatic t_irq();
        h.wr(A_IRQEN, 8'h01);
        @(posedge mclk) pbs[2] <= 8'h09;
        repeat (3) @(posedge mclk);
        #1 chk("irq_on", 1'b1, irq);
        h.rd(12'hEA2, d); chk("pstat2", 8'h01, d);
        h.wr(A_IRQEN, 8'h00);
        repeat (3) @(posedge mclk);
        #1 chk("irq_off", 1'b0, irq);
        h.wr(A_IRQEN, 8'h80);
        @(posedge mclk) cls <= 4'h1;
        repeat (3) @(posedge mclk);
        #1 chk("irq_cls0", 1'b0, irq);
        @(posedge mclk) cls <= 4'h4;
        repeat (3) @(posedge mclk);
        #1 chk("irq_cls2", 1'b1, irq);
        h.rd(A_CLASS, d); chk("class", 8'h04, d);
        @(posedge mclk) begin
            cps <= 16'hFFFF;
            ups <= 16'hC210;
        end
        h.rd(12'hEA8, d); chk("cpu_lo", 8'hF7, d);
        h.rd(12'hEA9, d); chk("cpu_hi", 8'h3F, d);
        h.rd(12'hEAA, d); chk("up_lo", 8'h10, d);
        h.rd(12'hEAB, d); chk("up_hi", 8'h02, d);
        h.wr(A_IRQEN, 8'h00);
    endtask
    // Per-port control levels, reserved bits hidden, and memory repair override.
    task automatic t_ctl();
        h.wr(12'hEB3, 8'hFF);
        repeat (2) @(posedge mclk);
        #1 chk("qctl3", 5'h1F, {su[3], qr[3], fm[3], xf[3], xn[3]});
        h.rd(12'hEB3, d); chk("qctl3_rd", QCTL_MASK, d);
        h.wr(A_REPAIR, 8'h0A); repeat (2) @(posedge mclk);
        #1 chk("swap_ovr", 4'hA, sm);
        h.wr(A_REPAIR, 8'h00); repeat (2) @(posedge mclk);
        #1 chk("swap_hw", hw, sm);
        h.wr(A_QENG, 8'hF3);
        h.rd(A_QENG, d); chk("qeng_rd", 8'h03, d);
        chk("halts", 4'h3, {rs, gs, mh, qh});
    endtask
    // A machine busy through a whole window raises the reset unless masked; heartbeat bits read live.
    task automatic t_watch();
        @(posedge mclk) begin
            busy[0][0] <= 1'b1;
            hbs[0] <= 1'b1;
            hbt[0] <= 1'b1;
        end
        repeat (40) @(posedge mclk);
        #1 chk("tmo_on", 1'b1, tr);
        h.rd(A_WATCH, d); chk("watch0", 8'hC1, d);
        h.wr(A_IRQEN, 8'h40);
        h.wr(A_MASK, 8'h01);
        repeat (2) @(posedge mclk);
        #1 chk("tmo_mask", 1'b0, tr);
        chk("irq_hb", 1'b1, irq);
        @(posedge mclk) begin
            busy[0][0] <= 1'b0;
            hbt[0] <= 1'b0;
        end
        h.rd(A_WATCH, d); chk("watch_idle", 8'h40, d);
        h.wr(A_IRQEN, 8'h00);
    endtask
    // One pulse per rising go bit; bit 4 selects every pool.
    task automatic t_pool(input logic [4:0] sel, input logic [14:0] e);
        h.pool(sel);
        #1 chk("stops", 2'b11, {gs, rs});
        @(posedge mclk);
        #1 chk("pulse", e, pul);
        @(posedge mclk);
        #1 chk("pulse_end", 15'h0, pul);
        h.wr(A_QENG, 8'h00);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        t_read();
        t_irq();
        t_ctl();
        t_watch();
        t_pool(5'h03, 15'h0008);
        t_pool(5'h13, 15'h7FFF);
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        mismatches++;
        stop_test();
    end
endmodule
